// ### verilog/epi_ext_irq.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
// What this block does
// - ten vectors, reset lowest, fixed order
// - pins trigger even when driven outputs
// - any masked pin change raises request
// - pin change detected without a clock
// - low level requests while pin low
// - edges need clock, low level wakes
// - short low level wakes without interrupt
// - sense field selects level, change, edges
// - pin sampled first, longer pulses caught
// - enable bit 6 gates external interrupt
// - enable bit 5 gates pin change
// - external flag sets, clears, zero level
// - pin change flag sets and clears
// - flag, enable, global enable cause jump
// - mask bits enable each pin change
// - reserved bits read as zero
module epi_ext_irq #(
  parameter int PC_PINS = epi_pkg::PC_WIDTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire epi_pkg::epi_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic ext_irq_pin,
  input wire logic [PC_PINS-1:0] pin_change_inputs,
  input wire logic [6:0] other_requests,
  input wire logic core_ack,
  output epi_pkg::epi_core_req_t core_req,
  output logic wake,
  output logic irq
);
  import epi_pkg::*;

  logic [PC_PINS-1:0] pin_change_mask;
  logic [1:0] ext_sense_select;
  logic ext_irq_enable;
  logic pin_change_enable;
  logic global_enable;
  logic ext_irq_flag;
  logic pin_change_flag;
  logic [1:0] int_status;
  logic [1:0] int_mask;
  logic ext_q;
  logic ext_qq;
  logic [PC_PINS-1:0] pc_q;
  logic [PC_PINS-1:0] pc_ref;
  logic ext_event;
  logic pc_event;
  logic level_req;
  logic ext_req;
  logic pc_req;
  logic [3:0] next_vector;
  logic any_req;
  logic wr_flags;
  logic rd_status;
  epi_sense_t sense;

  assign sense = epi_sense_t'(ext_sense_select);
  assign wr_flags = clk_en && reg_req.wr && reg_req.addr == OFS_IRQ_FLAGS;
  assign rd_status = clk_en && reg_req.rd && reg_req.addr == OFS_INT_STATUS;

  ////////////////////////////////////////////////////////////////////////
  // pin sampling
  // inputs are sampled whatever the port direction, so software drives them
  // pins as outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_q <= 1'b1;
      ext_qq <= 1'b1;
      pc_q <= '0;
      pc_ref <= '0;
    end else if (clk_en) begin
      ext_q <= ext_irq_pin;
      ext_qq <= ext_q;
      pc_q <= pin_change_inputs;
      pc_ref <= pc_q;
    end
  end

  // edge and change detection on the sampled external pin
  // sense select decode
  always_comb begin
    unique case (sense)
      SENSE_LOW: ext_event = 1'b0;
      SENSE_ANY: ext_event = ext_q != ext_qq;
      SENSE_FALL: ext_event = !ext_q && ext_qq;
      SENSE_RISE: ext_event = ext_q && !ext_qq;
    endcase
  end

  assign pc_event = |((pc_q ^ pc_ref) & pin_change_mask);

  // level request follows the raw pin so it acts while the clock is stopped
  // level request held
  assign level_req = sense == SENSE_LOW && !ext_irq_pin;

  // wake needs no clock: raw level and raw mismatch against the older sample pc_ref
  // clockless pin change
  assign wake = (ext_irq_enable && level_req)
    || (pin_change_enable && |((pin_change_inputs ^ pc_ref) & pin_change_mask));

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_change_mask <= '0;
      ext_sense_select <= 2'h0;
      ext_irq_enable <= 1'b0;
      pin_change_enable <= 1'b0;
      global_enable <= 1'b0;
      int_mask <= 2'h0;
    end else if (clk_en && reg_req.wr) begin
      unique case (reg_req.addr)
        OFS_PIN_CHANGE_MASK: pin_change_mask <= reg_req.wdata[PC_PINS-1:0];
        OFS_SENSE_CONTROL: ext_sense_select <= reg_req.wdata[1:0];
        OFS_IRQ_ENABLES: begin
          ext_irq_enable <= reg_req.wdata[EXT_BIT];
          pin_change_enable <= reg_req.wdata[PC_BIT];
        end
        OFS_GLOBAL_ENABLE: global_enable <= reg_req.wdata[GIE_BIT];
        OFS_INT_MASK: int_mask <= reg_req.wdata[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt flags; a new event wins over a clear in the same cycle
  // external flag
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_irq_flag <= 1'b0;
    end else if (clk_en) begin
      if (sense == SENSE_LOW) begin
        ext_irq_flag <= 1'b0;
      end else if (ext_event) begin
        ext_irq_flag <= 1'b1;
      end else if ((wr_flags && reg_req.wdata[EXT_BIT])
          || (core_ack && core_req.valid && core_req.vector == VEC_EXT)) begin
        ext_irq_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_change_flag <= 1'b0;
    end else if (clk_en) begin
      if (pc_event) begin
        pin_change_flag <= 1'b1;
      end else if ((wr_flags && reg_req.wdata[PC_BIT])
          || (core_ack && core_req.valid && core_req.vector == VEC_PIN_CHANGE)) begin
        pin_change_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request arbitration toward the core
  // level mode asks from the synchronised pin, no flag involved
  // level must persist
  assign ext_req = ext_irq_enable && (sense == SENSE_LOW ? !ext_qq : ext_irq_flag);
  assign pc_req = pin_change_enable && pin_change_flag;

  always_comb begin
    next_vector = VEC_RESET;
    any_req = 1'b1;
    if (ext_req) begin
      next_vector = VEC_EXT;
    end else if (pc_req) begin
      next_vector = VEC_PIN_CHANGE;
    end else if (other_requests[0]) begin
      next_vector = VEC_TIMER_OVF;
    end else if (other_requests[1]) begin
      next_vector = VEC_EEPROM_RDY;
    end else if (other_requests[2]) begin
      next_vector = VEC_COMPARATOR;
    end else if (other_requests[3]) begin
      next_vector = VEC_MATCH_A;
    end else if (other_requests[4]) begin
      next_vector = VEC_MATCH_B;
    end else if (other_requests[5]) begin
      next_vector = VEC_WATCHDOG;
    end else if (other_requests[6]) begin
      next_vector = VEC_ADC_DONE;
    end else begin
      any_req = 1'b0;
    end
  end

  // registered request; an ack drops it so a stale vector is never reused
  // gated jump request
  always_ff @(posedge clk) begin
    if (reset) begin
      core_req <= '0;
    end else if (clk_en) begin
      core_req.valid <= global_enable && any_req && !(core_ack && core_req.valid);
      core_req.vector <= next_vector;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status for the level interrupt output, cleared by reading it
  always_ff @(posedge clk) begin
    if (reset) begin
      int_status <= 2'h0;
    end else if (clk_en) begin
      int_status <= (rd_status ? 2'h0 : int_status) | {pc_event, ext_event};
    end
  end

  assign irq = |(int_status & int_mask);

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  // reserved read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= RST_ZERO;
    end else if (clk_en) begin
      reg_rdata <= RST_ZERO;
      if (reg_req.rd) begin
        unique case (reg_req.addr)
          OFS_PIN_CHANGE_MASK: reg_rdata <= 8'(pin_change_mask);
          // a flag still draining after a switch to level mode must not show
          OFS_IRQ_FLAGS: reg_rdata <= {1'b0, ext_irq_flag && sense != SENSE_LOW,
            pin_change_flag, 5'h00};
          OFS_SENSE_CONTROL: reg_rdata <= {6'h00, ext_sense_select};
          OFS_IRQ_ENABLES: reg_rdata <= {1'b0, ext_irq_enable, pin_change_enable, 5'h00};
          OFS_GLOBAL_ENABLE: reg_rdata <= {global_enable, 7'h00};
          OFS_INT_STATUS: reg_rdata <= {6'h00, int_status};
          OFS_INT_MASK: reg_rdata <= {6'h00, int_mask};
          OFS_VECTOR: reg_rdata <= {any_req, 3'h0, next_vector};
          default: reg_rdata <= RST_ZERO;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_level_flag_zero;
    @(posedge clk) disable iff (reset)
    (clk_en && sense == SENSE_LOW) |=> !ext_irq_flag;
  endproperty
  a_level_flag_zero: assert property (p_level_flag_zero) else $error("flag set in level mode");

  property p_fall_sets;
    @(posedge clk) disable iff (reset)
    (clk_en && sense == SENSE_FALL && !ext_q && ext_qq) |=> ext_irq_flag;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

  property p_pc_sets;
    @(posedge clk) disable iff (reset)
    (clk_en && |((pc_q ^ pc_ref) & pin_change_mask)) |=> pin_change_flag;
  endproperty
  a_pc_sets: assert property (p_pc_sets) else $error("pin change lost");

  property p_mask_blocks;
    @(posedge clk) disable iff (reset)
    (clk_en && !pin_change_flag && pin_change_mask == '0) |=> !pin_change_flag;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked pin set flag");

  property p_no_gie;
    @(posedge clk) disable iff (reset)
    (clk_en && !global_enable) |=> !core_req.valid;
  endproperty
  a_no_gie: assert property (p_no_gie) else $error("request without global enable");

  property p_ext_first;
    @(posedge clk) disable iff (reset)
    (clk_en && global_enable && ext_req && !(core_ack && core_req.valid))
      |=> core_req.valid && core_req.vector == VEC_EXT;
  endproperty
  a_ext_first: assert property (p_ext_first) else $error("external not first");

  property p_level_wake;
    @(posedge clk) disable iff (reset)
    (ext_irq_enable && sense == SENSE_LOW && !ext_irq_pin) |-> wake;
  endproperty
  a_level_wake: assert property (p_level_wake) else $error("level did not wake");

  property p_flag_clear_write;
    @(posedge clk) disable iff (reset)
    (wr_flags && reg_req.wdata[PC_BIT] && !pc_event) |=> !pin_change_flag;
  endproperty
  a_flag_clear_write: assert property (p_flag_clear_write) else $error("flag not cleared");

  property p_reserved_zero;
    @(posedge clk) disable iff (reset)
    (clk_en && reg_req.rd && reg_req.addr == OFS_IRQ_FLAGS) |=> reg_rdata[4:0] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_rise_sets;
    @(posedge clk) disable iff (reset)
    (clk_en && sense == SENSE_RISE && ext_q && !ext_qq) |=> ext_irq_flag;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

  property p_any_sets;
    @(posedge clk) disable iff (reset)
    (clk_en && sense == SENSE_ANY && ext_q != ext_qq) |=> ext_irq_flag;
  endproperty
  a_any_sets: assert property (p_any_sets) else $error("pin change of ext lost");

  property p_ext_clear_write;
    @(posedge clk) disable iff (reset)
    (wr_flags && reg_req.wdata[EXT_BIT] && !ext_event) |=> !ext_irq_flag;
  endproperty
  a_ext_clear_write: assert property (p_ext_clear_write) else $error("ext flag kept");

  property p_ext_clear_entry;
    @(posedge clk) disable iff (reset)
    (clk_en && core_ack && core_req.valid && core_req.vector == VEC_EXT && !ext_event)
      |=> !ext_irq_flag;
  endproperty
  a_ext_clear_entry: assert property (p_ext_clear_entry) else $error("entry kept flag");

  property p_pc_clear_entry;
    @(posedge clk) disable iff (reset)
    (clk_en && core_ack && core_req.valid && core_req.vector == VEC_PIN_CHANGE && !pc_event)
      |=> !pin_change_flag;
  endproperty
  a_pc_clear_entry: assert property (p_pc_clear_entry) else $error("entry kept pc flag");

  property p_ext_gated;
    @(posedge clk) disable iff (reset)
    (clk_en && !ext_irq_enable) |=> !(core_req.valid && core_req.vector == VEC_EXT);
  endproperty
  a_ext_gated: assert property (p_ext_gated) else $error("external not enabled");

  property p_pc_gated;
    @(posedge clk) disable iff (reset)
    (clk_en && !pin_change_enable) |=> !(core_req.valid && core_req.vector == VEC_PIN_CHANGE);
  endproperty
  a_pc_gated: assert property (p_pc_gated) else $error("pin change not enabled");

  property p_level_flag_read;
    @(posedge clk) disable iff (reset)
    (clk_en && reg_req.rd && reg_req.addr == OFS_IRQ_FLAGS && sense == SENSE_LOW)
      |=> !reg_rdata[EXT_BIT];
  endproperty
  a_level_flag_read: assert property (p_level_flag_read) else $error("level flag read");

  property p_pc_second;
    @(posedge clk) disable iff (reset)
    (clk_en && global_enable && !ext_req && pc_req && !(core_ack && core_req.valid))
      |=> core_req.valid && core_req.vector == VEC_PIN_CHANGE;
  endproperty
  a_pc_second: assert property (p_pc_second) else $error("pin change not second");

  property p_enables_reserved;
    @(posedge clk) disable iff (reset)
    (clk_en && reg_req.rd && reg_req.addr == OFS_IRQ_ENABLES)
      |=> !reg_rdata[7] && reg_rdata[4:0] == 5'h00;
  endproperty
  a_enables_reserved: assert property (p_enables_reserved) else $error("enable spare set");

  property p_ack_drops;
    @(posedge clk) disable iff (reset)
    (clk_en && core_ack && core_req.valid) |=> !core_req.valid;
  endproperty
  a_ack_drops: assert property (p_ack_drops) else $error("request kept after ack");

  property p_no_reset_vector;
    @(posedge clk) disable iff (reset)
    core_req.valid |-> core_req.vector != VEC_RESET;
  endproperty
  a_no_reset_vector: assert property (p_no_reset_vector) else $error("reset vector asked");
endmodule

// ### verilog/epi_pkg.sv
package epi_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] OFS_PIN_CHANGE_MASK = 8'h15;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h3a;
  localparam logic [7:0] OFS_SENSE_CONTROL = 8'h35;
  localparam logic [7:0] OFS_IRQ_ENABLES = 8'h3b;
  localparam logic [7:0] OFS_GLOBAL_ENABLE = 8'h3f;
  localparam logic [7:0] OFS_INT_STATUS = 8'h30;
  localparam logic [7:0] OFS_INT_MASK = 8'h31;
  localparam logic [7:0] OFS_VECTOR = 8'h32;
  // field positions
  localparam int EXT_BIT = 6;
  localparam int PC_BIT = 5;
  localparam int GIE_BIT = 7;
  localparam int PC_WIDTH = 6;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  // vector addresses
  localparam logic [3:0] VEC_RESET = 4'h0;
  localparam logic [3:0] VEC_EXT = 4'h1;
  localparam logic [3:0] VEC_PIN_CHANGE = 4'h2;
  localparam logic [3:0] VEC_TIMER_OVF = 4'h3;
  localparam logic [3:0] VEC_EEPROM_RDY = 4'h4;
  localparam logic [3:0] VEC_COMPARATOR = 4'h5;
  localparam logic [3:0] VEC_MATCH_A = 4'h6;
  localparam logic [3:0] VEC_MATCH_B = 4'h7;
  localparam logic [3:0] VEC_WATCHDOG = 4'h8;
  localparam logic [3:0] VEC_ADC_DONE = 4'h9;
  // sense select encodings
  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_ANY = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } epi_sense_t;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } epi_reg_req_t;
  // request toward the core
  typedef struct packed {
    logic valid;
    logic [3:0] vector;
  } epi_core_req_t;
endpackage

// ### sim/epi_partner.sv
`timescale 1ns/1ns
// far side: external pins plus a core that accepts requests
module epi_partner (
  input wire logic clk,
  input wire logic ext_cmd,
  input wire logic [5:0] pc_cmd,
  input wire logic ack_en,
  input wire epi_pkg::epi_core_req_t core_req,
  output logic ext_irq_pin,
  output logic [5:0] pin_change_inputs,
  output logic core_ack
);
  import epi_pkg::*;
  initial begin
    ext_irq_pin = 1'b1;
    pin_change_inputs = 6'h00;
    core_ack = 1'b0;
  end
  // level held
  // pins take the commanded level after an edge and keep it while asked
  always @(posedge clk) begin
    ext_irq_pin <= ext_cmd;
    pin_change_inputs <= pc_cmd;
  end
  // never two accepts in a row, so a pending request must drop and return
  always @(posedge clk) begin
    core_ack <= ack_en & core_req.valid & ~core_ack;
  end
endmodule

// ### sim/ext_pin_irq_and_vectors_tb_top.sv
`timescale 1ns/1ns
module ext_pin_irq_and_vectors_tb_top;
  import epi_pkg::*;
  logic clk, reset, clk_en, ext_cmd, ack_en, ext_irq_pin, core_ack, wake, irq;
  logic [5:0] pc_cmd, pin_change_inputs;
  logic [6:0] other_requests;
  logic [7:0] reg_rdata;
  epi_reg_req_t reg_req;
  epi_core_req_t core_req;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  epi_ext_irq dut (.clk(clk), .reset(reset), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin), .pin_change_inputs(pin_change_inputs),
    .other_requests(other_requests), .core_ack(core_ack), .core_req(core_req),
    .wake(wake), .irq(irq));
  epi_partner far (.clk(clk), .ext_cmd(ext_cmd), .pc_cmd(pc_cmd), .ack_en(ack_en),
    .core_req(core_req), .ext_irq_pin(ext_irq_pin), .pin_change_inputs(pin_change_inputs),
    .core_ack(core_ack));
  // 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard; the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    reg_req <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    reg_req <= '0;
    #1 check(what, reg_rdata, exp);
    // hand back on an edge so the next drive lands on one
    @(posedge clk);
  endtask
  // bounded wait for an accepted request, then judge its vector
  task automatic wait_vec(input logic [3:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (core_ack !== 1'b1 && n < 30);
    check("core request", {3'h0, core_req.valid, core_req.vector}, {4'h1, v});
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(OFS_PIN_CHANGE_MASK, RST_ZERO, "mask reset");
    rd(OFS_IRQ_FLAGS, RST_ZERO, "flags reset");
    wr(OFS_PIN_CHANGE_MASK, 8'hff);
    rd(OFS_PIN_CHANGE_MASK, 8'h3f, "mask reserved");
    wr(OFS_IRQ_ENABLES, 8'hff);
    rd(OFS_IRQ_ENABLES, 8'h60, "enables reserved");
    wr(OFS_IRQ_FLAGS, 8'hff);
    rd(OFS_IRQ_FLAGS, 8'h00, "flags reserved");
    rd(8'h00, 8'h00, "unmapped");
    wr(OFS_PIN_CHANGE_MASK, 8'h01);
  endtask
  // every sense code against a falling then a rising pin
  task automatic t_sense();
    logic [3:0] on_fall = 4'b0110;
    logic [3:0] on_rise = 4'b1010;
    wr(OFS_GLOBAL_ENABLE, 8'h80);
    wr(OFS_IRQ_ENABLES, 8'h40);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_SENSE_CONTROL, 8'(m));
      rd(OFS_SENSE_CONTROL, 8'(m), "sense readback");
      wr(OFS_IRQ_FLAGS, 8'h40);
      ext_cmd <= 1'b0;
      tick(4);
      rd(OFS_IRQ_FLAGS, {1'b0, on_fall[m], 6'h0}, "flag on fall");
      if (m == 0) check("level request", {7'h0, core_req.valid}, 8'h01);
      wr(OFS_IRQ_FLAGS, 8'h40);
      ext_cmd <= 1'b1;
      tick(4);
      rd(OFS_IRQ_FLAGS, {1'b0, on_rise[m], 6'h0}, "flag on rise");
      if (m == 0) check("level gone", {7'h0, core_req.valid}, 8'h00);
    end
    // the rising pass left the flag set; level mode must hide it
    wr(OFS_SENSE_CONTROL, {6'h0, SENSE_LOW});
    rd(OFS_IRQ_FLAGS, 8'h00, "flag in level mode");
  endtask
  task automatic t_pc();
    wr(OFS_IRQ_FLAGS, 8'h60);
    wr(OFS_IRQ_ENABLES, 8'h20);
    pc_cmd <= 6'h02;
    tick(4);
    rd(OFS_IRQ_FLAGS, 8'h00, "unmasked pin");
    pc_cmd <= 6'h03;
    tick(4);
    rd(OFS_IRQ_FLAGS, 8'h20, "masked pin");
    ack_en <= 1'b1;
    wait_vec(VEC_PIN_CHANGE);
    ack_en <= 1'b0;
    tick(2);
    rd(OFS_IRQ_FLAGS, 8'h00, "flag after entry");
  endtask
  task automatic t_order();
    wr(OFS_IRQ_ENABLES, 8'h60);
    wr(OFS_SENSE_CONTROL, {6'h0, SENSE_FALL});
    ext_cmd <= 1'b0;
    pc_cmd <= 6'h02;
    tick(4);
    ack_en <= 1'b1;
    wait_vec(VEC_EXT);
    wait_vec(VEC_PIN_CHANGE);
    for (int i = 0; i < 7; i++) begin
      ack_en <= 1'b0;
      other_requests <= 7'(1 << i);
      tick(3);
      ack_en <= 1'b1;
      wait_vec(VEC_TIMER_OVF + 4'(i));
    end
    ack_en <= 1'b0;
    wr(OFS_GLOBAL_ENABLE, 8'h00);
    tick(3);
    check("no global enable", {7'h0, core_req.valid}, 8'h00);
    rd(OFS_VECTOR, {1'b1, 3'h0, VEC_ADC_DONE}, "vector readout");
    rd(OFS_GLOBAL_ENABLE, 8'h00, "global enable off");
    other_requests <= 7'h00;
  endtask
  // status is sticky until read; the interrupt follows status and mask
  task automatic t_irq();
    check("irq masked", {7'h0, irq}, 8'h00);
    rd(OFS_INT_STATUS, 8'h03, "status events");
    wr(OFS_INT_MASK, 8'h01);
    rd(OFS_INT_MASK, 8'h01, "mask readback");
    ext_cmd <= 1'b1;
    tick(4);
    ext_cmd <= 1'b0;
    tick(4);
    check("irq raised", {7'h0, irq}, 8'h01);
    rd(OFS_INT_STATUS, 8'h01, "status ext");
    check("irq cleared", {7'h0, irq}, 8'h00);
  endtask
  // the clock is gated off, so only the clockless paths can wake
  task automatic t_wake();
    wr(OFS_SENSE_CONTROL, {6'h0, SENSE_LOW});
    ext_cmd <= 1'b1;
    tick(3);
    clk_en <= 1'b0;
    ext_cmd <= 1'b0;
    tick(2);
    check("level wake", {7'h0, wake}, 8'h01);
    ext_cmd <= 1'b1;
    pc_cmd <= 6'h03;
    tick(2);
    check("change wake", {7'h0, wake}, 8'h01);
    clk_en <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    reg_req = '0;
    ext_cmd = 1'b1;
    pc_cmd = 6'h00;
    ack_en = 1'b0;
    other_requests = 7'h00;
    tick(20);
    reset <= 1'b0;
    t_regs();
    t_sense();
    t_pc();
    t_order();
    t_irq();
    t_wake();
    complete_run();
  end
endmodule
